// ### hdl/apbsi_consts.svh
`ifndef APBSI_CONSTS_SVH
`define APBSI_CONSTS_SVH
`define APBSI_AW 32
`define APBSI_DW 32
`define APBSI_NREG 4
`define APBSI_IDX_LO 2
`define APBSI_IDX_HI 3
`define APBSI_REG_RST 32'h00000000
`define APBSI_CTRL_IDX 2'h0
`define APBSI_RO_IDX 2'h3
`endif

// ### hdl/apbsi_pkg.sv
`include "apbsi_consts.svh"
package apbsi_pkg;
  typedef struct packed {
    logic [`APBSI_AW-1:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [`APBSI_DW-1:0] pwdata;
  } apbsi_req_t;
  typedef struct packed {
    logic [`APBSI_DW-1:0] prdata;
    logic pready;
    logic pslverr;
  } apbsi_rsp_t;
  typedef enum logic [1:0] {APBSI_IDLE, APBSI_RD_WAIT, APBSI_RD_DONE} apbsi_state_t;
endpackage

// ### hdl/apbsi_reg.sv
`timescale 1ns/1ps
`include "apbsi_consts.svh"
module apbsi_reg
  import apbsi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // write side
  input wire logic wr_en,
  input wire logic [`APBSI_DW-1:0] wr_data,
  // stored value
  output logic [`APBSI_DW-1:0] value
);
  logic [`APBSI_DW-1:0] next_value;

  always_comb begin
    next_value = value;
    if (wr_en) begin
      next_value = wr_data;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      value <= `APBSI_REG_RST;
    end else begin
      value <= next_value;
    end
  end
endmodule

// ### hdl/apbsi_top.sv
// Overview of operation
// - all transfers timed on rising clock edge
// - active-low reset returns interface to idle
// - write high means write, low read
// - only selected slave drives read data
// - ready low inserts wait cycles
// - optional error output, else held low
// - bus idles with no select
// - ready low keeps transfer in access
// - read data valid when ready high
// - strobes derived from bus control signals
// - writes forward address, data; reads return
// - write strobe needs select, write, enable
// - read strobe decoded in first transfer cycle, high in second
`timescale 1ns/1ps
`include "apbsi_consts.svh"
module apbsi_top
  import apbsi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus from master
  input wire apbsi_req_t bus_req,
  // answer to master
  output apbsi_rsp_t bus_rsp,
  // user side: control register and status input
  output logic [`APBSI_DW-1:0] user_ctrl,
  input wire logic [`APBSI_DW-1:0] user_status,
  // user side strobes
  output logic user_wr_en,
  output logic user_rd_en,
  output logic [`APBSI_AW-1:0] user_addr,
  output logic [`APBSI_DW-1:0] user_wdata
);
  apbsi_state_t state, next_state;
  logic [`APBSI_DW-1:0] rd_mux, next_rdata, rdata_q;
  logic next_ready, next_err, ready_q, err_q;
  logic next_wr_en, next_rd_en;
  logic [`APBSI_AW-1:0] next_addr;
  logic [`APBSI_DW-1:0] next_wdata;
  logic [`APBSI_NREG-1:0] reg_wr;
  logic [`APBSI_DW-1:0] regs [`APBSI_NREG];
  logic [`APBSI_IDX_HI-`APBSI_IDX_LO:0] idx;
  logic wr_cyc, rd_setup, wr_setup;
  localparam int IDX_W = `APBSI_IDX_HI - `APBSI_IDX_LO + 1;

  assign idx = bus_req.paddr[`APBSI_IDX_HI:`APBSI_IDX_LO];
  assign wr_cyc = bus_req.psel && bus_req.pwrite && bus_req.penable;
  assign rd_setup = bus_req.psel && !bus_req.pwrite && !bus_req.penable;
  assign wr_setup = bus_req.psel && bus_req.pwrite && !bus_req.penable;

  // registers 0..2 writable; the last reads the user status
  genvar g;
  generate
    for (g = 0; g < `APBSI_NREG - 1; g++) begin : g_reg
      assign reg_wr[g] = wr_cyc && (idx == IDX_W'(g));
      apbsi_reg u_reg (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .wr_en(reg_wr[g]),
        .wr_data(bus_req.pwdata),
        .value(regs[g])
      );
    end
  endgenerate
  assign reg_wr[`APBSI_NREG-1] = 1'b0;
  assign regs[`APBSI_NREG-1] = user_status;

  always_comb begin
    rd_mux = regs[idx];
  end

  // reads take one wait cycle so data comes from a register, not the bus
  always_comb begin
    next_state = state;
    next_ready = 1'b0;
    next_err = 1'b0;
    next_rdata = '0;
    next_wr_en = wr_cyc;
    next_rd_en = rd_setup;
    next_addr = bus_req.paddr;
    next_wdata = bus_req.pwdata;
    case (state)
      APBSI_IDLE: begin
        if (rd_setup) begin
          next_state = APBSI_RD_WAIT;
        end else if (wr_setup) begin
          next_ready = 1'b1; // writes complete in two cycles
        end
      end
      APBSI_RD_WAIT: begin
        next_rdata = rd_mux;
        next_ready = 1'b1;
        next_state = APBSI_RD_DONE;
      end
      APBSI_RD_DONE: begin
        next_state = APBSI_IDLE;
      end
      default: next_state = APBSI_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state <= APBSI_IDLE;
      ready_q <= 1'b0;
      err_q <= 1'b0;
      rdata_q <= '0;
      user_wr_en <= 1'b0;
      user_rd_en <= 1'b0;
      user_addr <= '0;
      user_wdata <= '0;
    end else begin
      state <= next_state;
      ready_q <= next_ready;
      err_q <= next_err;
      rdata_q <= next_rdata;
      user_wr_en <= next_wr_en;
      user_rd_en <= next_rd_en;
      user_addr <= next_addr;
      user_wdata <= next_wdata;
    end
  end

  assign bus_rsp.prdata = rdata_q;
  assign bus_rsp.pready = ready_q;
  assign bus_rsp.pslverr = err_q;
  assign user_ctrl = regs[`APBSI_CTRL_IDX];

  // answer timing
  a_wait_then_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == APBSI_IDLE && rd_setup) |=> !bus_rsp.pready ##1 bus_rsp.pready)
    else $error("read not ready");

  a_wr_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == APBSI_IDLE && wr_setup) |=> bus_rsp.pready)
    else $error("write not ready");

  a_ready_needs_sel: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus_rsp.pready |-> $past(bus_req.psel))
    else $error("ready without select");

  a_ready_pulse: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus_rsp.pready |=> !bus_rsp.pready)
    else $error("ready too long");

  a_rd_done_idle: assert property (@(posedge ref_clk) disable iff (!rstn)
    state == APBSI_RD_DONE |=> state == APBSI_IDLE)
    else $error("read did not finish");

  a_idle_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    (state == APBSI_IDLE && !wr_setup) |=> !bus_rsp.pready)
    else $error("ready while idle");

  // read data and error
  a_ready_holds_data: assert property (@(posedge ref_clk) disable iff (!rstn)
    (bus_rsp.pready && $past(state) == APBSI_RD_WAIT) |-> bus_rsp.prdata == $past(rd_mux))
    else $error("read data mismatch");

  a_rdata_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    $past(state) != APBSI_RD_WAIT |-> bus_rsp.prdata == '0)
    else $error("stray read data");

  a_rdata_only_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
    bus_rsp.prdata != '0 |-> bus_rsp.pready)
    else $error("read data outside ready");

  a_err_low: assert property (@(posedge ref_clk) disable iff (!rstn)
    !bus_rsp.pslverr)
    else $error("error raised");

  // user-side strobes and forwarding
  a_wr_strobe: assert property (@(posedge ref_clk) disable iff (!rstn)
    user_wr_en |-> $past(wr_cyc))
    else $error("bad write strobe");

  a_rd_strobe: assert property (@(posedge ref_clk) disable iff (!rstn)
    rd_setup |=> user_rd_en)
    else $error("missing read strobe");

  a_rd_strobe_src: assert property (@(posedge ref_clk) disable iff (!rstn)
    user_rd_en |-> $past(rd_setup))
    else $error("stray read strobe");

  a_strobes_apart: assert property (@(posedge ref_clk) disable iff (!rstn)
    !(user_wr_en && user_rd_en))
    else $error("both strobes high");

  a_wdata_fwd: assert property (@(posedge ref_clk) disable iff (!rstn)
    user_wr_en |-> user_wdata == $past(bus_req.pwdata))
    else $error("write data not forwarded");

  a_addr_fwd: assert property (@(posedge ref_clk) disable iff (!rstn)
    user_wr_en |-> user_addr == $past(bus_req.paddr))
    else $error("address not forwarded");

  // register contents and reset
  a_reg_write: assert property (@(posedge ref_clk) disable iff (!rstn)
    ($past(wr_cyc) && $past(idx) == `APBSI_CTRL_IDX) |-> user_ctrl == $past(bus_req.pwdata))
    else $error("control write lost");

  a_ctrl_hold: assert property (@(posedge ref_clk) disable iff (!rstn)
    (!$past(wr_cyc) || $past(idx) != `APBSI_CTRL_IDX) |-> $stable(user_ctrl))
    else $error("control changed without write");

  a_reset_idle: assert property (@(posedge ref_clk)
    !rstn |-> state == APBSI_IDLE)
    else $error("not idle in reset");
endmodule

// ### tb/apbsi_master.sv
`timescale 1ns/1ps
module apbsi_master
  import apbsi_pkg::*;
(
  // clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // bus
  output apbsi_req_t bus_req,
  input wire apbsi_rsp_t bus_rsp
);
  initial bus_req = '0;
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] d,
    output logic [31:0] rd, output int waits);
    @(posedge ref_clk) #1;
    bus_req.psel = 1'b1;
    bus_req.pwrite = wr;
    bus_req.paddr = a;
    bus_req.pwdata = d;
    @(posedge ref_clk) #1;
    bus_req.penable = 1'b1;
    waits = 0;
    @(posedge ref_clk);
    while (bus_rsp.pready !== 1'b1 && waits < 20) begin
      waits++;
      @(posedge ref_clk);
    end
    rd = bus_rsp.prdata;
    #1;
    bus_req.psel = 1'b0;
    bus_req.penable = 1'b0;
    // released lines flip so a stale value cannot pass
    bus_req.paddr = ~a;
    bus_req.pwdata = ~d;
  endtask
endmodule

// ### tb/tb_top.sv
`timescale 1ns/1ps
`include "apbsi_consts.svh"
module tb_top;
  import apbsi_pkg::*;
  logic ref_clk = 1'b0;
  logic rstn = 1'b1;
  logic [31:0] user_status = 32'h5A5A00C3;
  apbsi_req_t bus_req;
  apbsi_rsp_t bus_rsp;
  logic [31:0] user_ctrl, user_addr, user_wdata, rd;
  logic user_wr_en, user_rd_en;
  int n_mismatch = 0;
  int checks = 0;
  int w;
  int n_rd_pulse = 0;
  always #25 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    if (user_rd_en === 1'b1) begin
      n_rd_pulse++;
    end
  end
  apbsi_top dut(.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .bus_rsp(bus_rsp),
    .user_ctrl(user_ctrl), .user_status(user_status), .user_wr_en(user_wr_en),
    .user_rd_en(user_rd_en), .user_addr(user_addr), .user_wdata(user_wdata));
  apbsi_master m(.ref_clk(ref_clk), .rstn(rstn), .bus_req(bus_req), .bus_rsp(bus_rsp));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: %s", $time, msg);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic t_reset;
    chk(bus_rsp.prdata, 32'h0, "prdata after reset");
    chk({31'h0, bus_rsp.pslverr}, 32'h0, "error flag");
    chk(user_ctrl, `APBSI_REG_RST, "ctrl reset value");
  endtask
  task automatic t_write_read;
    int base;
    for (int i = 0; i < 3; i++) begin
      base = n_rd_pulse;
      m.xfer(1'b1, i << 2, 32'hA5000010 + i, rd, w);
      chk(w, 0, "write waits");
      chk({31'h0, user_wr_en}, 32'h1, "write strobe");
      chk(user_wdata, 32'hA5000010 + i, "write data");
      chk(user_addr, i << 2, "write address");
      chk(n_rd_pulse - base, 0, "read strobe on write");
      if (i == 0) chk(user_ctrl, 32'hA5000010, "ctrl value");
      m.xfer(1'b0, 32'hF0000000 | (i << 2), 32'h0, rd, w);
      chk(w, 1, "read waits");
      chk(rd, 32'hA5000010 + i, "read back");
      chk(user_addr, 32'hF0000000 | (i << 2), "read address");
      chk(n_rd_pulse - base, 1, "read strobe count");
      chk(bus_rsp.prdata, 32'h0, "prdata idle");
    end
  endtask
  task automatic t_status;
    m.xfer(1'b1, 32'hC, 32'h12345678, rd, w);
    chk(user_ctrl, 32'hA5000010, "status slot write ignored");
    m.xfer(1'b0, 32'hC, 32'h0, rd, w);
    chk(rd, 32'h5A5A00C3, "status read");
    chk({31'h0, bus_rsp.pslverr}, 32'h0, "error flag");
  endtask
  initial begin
    #1 rstn = 1'b0;
    repeat (16) @(posedge ref_clk);
    #1 rstn = 1'b1;
    t_reset();
    t_write_read();
    t_status();
    final_report();
  end
  initial begin
    #(2000 * 50);
    n_mismatch++;
    final_report();
  end
endmodule
